/* frame_capture_asserts.sv */
`timescale 1ns/1ns
module frame_capture_asserts
  import tape_reader_pkg::*;
#(
  parameter int WINDOW_CYCLES = 35,
  parameter int GRACE_CYCLES = 20
) (
  // Watched ports
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sample_pulse,
  input wire logic control_register_clear,
  input wire logic lockout_release,
  input wire logic frame_read_ack,
  input wire logic missing_strobe_indicator,
  input wire logic class_b_fault,
  input wire logic processor_halt,
  input wire logic tape_feed
);
  int hi_cnt;
  int gap_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ========
  // Pulse length and gap since last sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt <= 0;
      gap_cnt <= 0;
    end else begin
      hi_cnt <= sample_pulse ? hi_cnt + 1 : 0;
      gap_cnt <= (sample_pulse && hi_cnt == 0) ? 1 : gap_cnt + 1;
    end
  end
  // ========
  // Properties
  AST_PULSE_LEN: assert property (
    $fell(sample_pulse) |-> hi_cnt == SAMPLE_CYC)
    else $error("sample pulse length wrong");
  AST_CLR_RELEASE: assert property (
    control_register_clear == lockout_release)
    else $error("clear and release differ");
  AST_CLR_ONE: assert property (
    control_register_clear |=> !control_register_clear)
    else $error("clear pulse too long");
  AST_ACK_FRAME: assert property (
    frame_read_ack |-> sample_pulse && tape_feed ##1 !frame_read_ack)
    else $error("read ack out of place");
  AST_FAULT_COPY: assert property (
    class_b_fault == missing_strobe_indicator
    && processor_halt == missing_strobe_indicator)
    else $error("fault outputs disagree");
  AST_FAULT_STOPS_FEED: assert property (
    missing_strobe_indicator ##1 missing_strobe_indicator |-> !tape_feed)
    else $error("feed still on in fault");
  AST_MISS_GAP: assert property (
    $rose(missing_strobe_indicator) |-> gap_cnt inside
    {[WINDOW_CYCLES + GRACE_CYCLES - 6:WINDOW_CYCLES + GRACE_CYCLES + 6]})
    else $error("missing strobe latched at wrong time");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule : frame_capture_asserts

bind tape_frame_capture frame_capture_asserts #(
  .WINDOW_CYCLES(WINDOW_CYCLES),
  .GRACE_CYCLES(GRACE_CYCLES)
) u_asserts (
  .hclk, .hresetn, .hreadyout, .hresp, .sample_pulse,
  .control_register_clear, .lockout_release, .frame_read_ack,
  .missing_strobe_indicator, .class_b_fault, .processor_halt, .tape_feed
);

/* tape_frame_capture.sv */
// Functional notes
// - Sample frame on strobe rising trailing edge
// - Sampling pulse positive, about quarter microsecond
// - Strobe during command clears control, releases lockout
// - Reading strobe samples, clocks watchdog, acknowledges
// - Holes set low seven bits, rest zero
// - Missing strobe while running latches fault
// - Watchdog inhibited seven milliseconds after start
// - Single gated tick with select, start launches holdoff
// - Stop sets pending; next strobe clears feed
// - Watchdog armed: holdoff expired and feed set
// - Strobe retriggers 3.5 millisecond window timer
// - Grace timer started by window timer expiry
// - Fault only when window idle and grace timer at last count
// - Grace lapses two milliseconds later, fault latches
// - Fault halts processor and reader, lights indicator
// - Stop-ending strobe clears flags, blocks ticks 3ms
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module tape_frame_capture
  import tape_reader_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = tape_reader_pkg::HOLDOFF_CYC,
  parameter int WINDOW_CYCLES = tape_reader_pkg::WINDOW_CYC,
  parameter int GRACE_CYCLES = tape_reader_pkg::GRACE_CYC,
  parameter int BLOCK_CYCLES = tape_reader_pkg::BLOCK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Reader link
  input wire logic link_clk,
  input wire logic strobe_n,
  input wire logic [tape_reader_pkg::FRAME_W-1:0] hole_levels,
  output logic tape_feed,
  // Processor side events and fault
  output logic sample_pulse,
  output logic control_register_clear,
  output logic lockout_release,
  output logic frame_read_ack,
  output logic missing_strobe_indicator,
  output logic class_b_fault,
  output logic processor_halt
);
  import tape_reader_pkg::*;

  localparam logic [TIMER_W-1:0] HOLDOFF_LD = TIMER_W'(HOLDOFF_CYCLES);
  localparam logic [TIMER_W-1:0] WINDOW_LD = TIMER_W'(WINDOW_CYCLES);
  localparam logic [TIMER_W-1:0] GRACE_LD = TIMER_W'(GRACE_CYCLES);
  localparam logic [TIMER_W-1:0] BLOCK_LD = TIMER_W'(BLOCK_CYCLES);
  localparam logic [PULSE_W-1:0] SAMPLE_LD = PULSE_W'(SAMPLE_CYC);
  localparam logic [TIMER_W-1:0] T_ONE = 20'h0_0001;
  localparam logic [TIMER_W-1:0] T_ZERO = 20'h0_0000;

  // ==========================================================
  // Link domain: strobe edge capture
  logic strobe_s1_reg;
  logic strobe_s2_reg;
  logic strobe_s3_reg;
  logic [FRAME_W-1:0] holes_s1_reg;
  logic [FRAME_W-1:0] holes_s2_reg;
  logic [FRAME_W-1:0] frame_reg;
  logic frame_tgl_reg;

  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_s1_reg <= 1'b1;
      strobe_s2_reg <= 1'b1;
      strobe_s3_reg <= 1'b1;
      holes_s1_reg <= '0;
      holes_s2_reg <= '0;
    end else begin
      strobe_s1_reg <= strobe_n;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
      holes_s1_reg <= hole_levels;
      holes_s2_reg <= holes_s1_reg;
    end
  end

  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      frame_reg <= '0;
      frame_tgl_reg <= 1'b0;
    end else if (strobe_s2_reg && !strobe_s3_reg) begin
      frame_reg <= holes_s2_reg;
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // ==========================================================
  // Event crossing into hclk
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic strobe_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= frame_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign strobe_evt = tgl_s2_reg ^ tgl_s3_reg;

  // ==========================================================
  // AHB-Lite slave
  logic accept;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic ctrl_wr;
  logic status_wr;
  logic [31:0] ctrl_reg;
  logic [31:0] tape_input_register;
  logic [31:0] status_word;
  logic [31:0] rdata_next;

  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == CTRL_OFF);
  assign status_wr = wr_pend_reg && (wr_addr_reg == STATUS_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= accept && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      unique case (haddr[7:0])
        CTRL_OFF: rdata_next = ctrl_reg;
        INPUT_OFF: rdata_next = tape_input_register;
        STATUS_OFF: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RDATA_RESET;
    end else if (accept && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // ==========================================================
  // Timers
  logic [TIMER_W-1:0] holdoff_cnt_reg;
  logic [TIMER_W-1:0] window_cnt_reg;
  logic [TIMER_W-1:0] grace_cnt_reg;
  logic [TIMER_W-1:0] block_cnt_reg;
  logic [PULSE_W-1:0] pulse_cnt_reg;
  logic holdoff_idle;
  logic window_idle;
  logic grace_idle;
  logic block_idle;

  assign holdoff_idle = (holdoff_cnt_reg == T_ZERO);
  assign window_idle = (window_cnt_reg == T_ZERO);
  assign grace_idle = (grace_cnt_reg == T_ZERO);
  assign block_idle = (block_cnt_reg == T_ZERO);

  // ==========================================================
  // Reader command flags
  logic feed_reg;
  logic stop_pending_flag;
  logic sel_bit;
  logic start_bit;
  logic stop_bit;
  logic start_cond;
  logic stop_cond;
  logic gated_tick;
  logic end_stop;
  logic armed;
  logic fault_evt;

  assign sel_bit = ctrl_reg[SEL_BIT];
  assign start_bit = ctrl_reg[START_BIT];
  assign stop_bit = ctrl_reg[STOP_BIT];
  assign start_cond = start_bit && !feed_reg && !stop_pending_flag;
  assign stop_cond = stop_bit && !start_bit && feed_reg && !stop_pending_flag;
  assign gated_tick = sel_bit && block_idle && !class_b_fault
    && (start_cond || stop_cond);
  assign end_stop = strobe_evt && stop_pending_flag;
  assign armed = holdoff_idle && feed_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feed_reg <= 1'b0;
      stop_pending_flag <= 1'b0;
    end else if (end_stop) begin
      feed_reg <= 1'b0;
      stop_pending_flag <= 1'b0;
    end else if (gated_tick && start_cond) begin
      feed_reg <= 1'b1;
      stop_pending_flag <= stop_bit;
    end else if (gated_tick) begin
      stop_pending_flag <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= hwdata;
    end else if (strobe_evt && (sel_bit || stop_pending_flag)) begin
      ctrl_reg <= CTRL_RESET;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      holdoff_cnt_reg <= T_ZERO;
    end else if (gated_tick && start_cond) begin
      holdoff_cnt_reg <= HOLDOFF_LD;
    end else if (!holdoff_idle) begin
      holdoff_cnt_reg <= holdoff_cnt_reg - T_ONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_cnt_reg <= T_ZERO;
    end else if (end_stop) begin
      block_cnt_reg <= BLOCK_LD;
    end else if (!block_idle) begin
      block_cnt_reg <= block_cnt_reg - T_ONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      window_cnt_reg <= T_ZERO;
    end else if (strobe_evt) begin
      window_cnt_reg <= WINDOW_LD;
    end else if (!window_idle) begin
      window_cnt_reg <= window_cnt_reg - T_ONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grace_cnt_reg <= T_ZERO;
    end else if (window_cnt_reg == T_ONE && !strobe_evt) begin
      grace_cnt_reg <= GRACE_LD;
    end else if (!grace_idle) begin
      grace_cnt_reg <= grace_cnt_reg - T_ONE;
    end
  end

  // ==========================================================
  // Missing strobe detection
  assign fault_evt = armed && window_idle && !strobe_evt
    && (grace_cnt_reg == T_ONE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      missing_strobe_indicator <= 1'b0;
    end else if (fault_evt) begin
      missing_strobe_indicator <= 1'b1;
    end else if (status_wr && hwdata[ST_MISSING]) begin
      missing_strobe_indicator <= 1'b0;
    end
  end

  assign class_b_fault = missing_strobe_indicator;
  assign processor_halt = missing_strobe_indicator;
  assign tape_feed = feed_reg && !missing_strobe_indicator;

  // ==========================================================
  // Frame sampling and strobe outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tape_input_register <= INPUT_RESET;
    end else if (strobe_evt) begin
      tape_input_register <= {25'h000_0000, frame_reg};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt_reg <= '0;
    end else if (strobe_evt) begin
      pulse_cnt_reg <= SAMPLE_LD;
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - PULSE_W'(1);
    end
  end

  assign sample_pulse = (pulse_cnt_reg != '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_register_clear <= 1'b0;
      lockout_release <= 1'b0;
      frame_read_ack <= 1'b0;
    end else begin
      control_register_clear <= strobe_evt
        && (sel_bit || stop_pending_flag);
      lockout_release <= strobe_evt && (sel_bit || stop_pending_flag);
      frame_read_ack <= strobe_evt && feed_reg
        && !stop_pending_flag;
    end
  end

  // ==========================================================
  // Status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_MISSING] = missing_strobe_indicator;
    status_word[ST_FAULT] = class_b_fault;
    status_word[ST_FEED] = feed_reg;
    status_word[ST_STOP] = stop_pending_flag;
    status_word[ST_HOLDOFF] = !holdoff_idle;
    status_word[ST_BLOCK] = !block_idle;
    status_word[ST_WINDOW] = !window_idle;
    status_word[ST_GRACE] = !grace_idle;
  end
endmodule : tape_frame_capture

/* tape_reader_model.sv */
`timescale 1ns/1ns
module tape_reader_model (
  // Link side
  input wire logic link_clk,
  input wire logic tape_feed,
  input wire logic drop,
  input wire logic [6:0] frame_in,
  output logic strobe_n,
  output logic [6:0] hole_levels,
  output logic [6:0] frame_sent
);
  logic [2:0] phase;
  logic skip;
  initial begin
    phase = 3'h0;
    skip = 1'b0;
    strobe_n = 1'b1;
    hole_levels = 7'h00;
    frame_sent = 7'h00;
  end
  // ========
  // One strobe per frame while the tape moves
  always @(posedge link_clk) begin
    if (phase != 3'h0 || tape_feed) phase <= phase + 3'h1;
    if (phase == 3'h0 && tape_feed) begin
      hole_levels <= frame_in;
      frame_sent <= frame_in;
      skip <= drop;
    end
    strobe_n <= !(phase inside {3'h1, 3'h2}) || skip;
    if (phase == 3'h7) hole_levels <= ~hole_levels;
  end
endmodule : tape_reader_model

/* tape_reader_pkg.sv */
package tape_reader_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] INPUT_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  // ==========================================================
  // Control field positions
  localparam int SEL_BIT = 17;
  localparam int START_BIT = 16;
  localparam int STOP_BIT = 15;
  // ==========================================================
  // Status field positions
  localparam int ST_MISSING = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_FEED = 2;
  localparam int ST_STOP = 3;
  localparam int ST_HOLDOFF = 4;
  localparam int ST_BLOCK = 5;
  localparam int ST_WINDOW = 6;
  localparam int ST_GRACE = 7;
  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] INPUT_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // ==========================================================
  // Widths
  localparam int FRAME_W = 7;
  localparam int TIMER_W = 20;
  localparam int PULSE_W = 6;
  // ==========================================================
  // Times and derived cycle counts
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_NS = 250;
  localparam int HOLDOFF_US = 7000;
  localparam int WINDOW_US = 3500;
  localparam int GRACE_US = 2000;
  localparam int BLOCK_US = 3000;
  localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int GRACE_CYC = GRACE_US * CLK_MHZ;
  localparam int BLOCK_CYC = BLOCK_US * CLK_MHZ;
endpackage : tape_reader_pkg

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import tape_reader_pkg::*;
  logic hclk, link_clk, hresetn, hsel, hwrite, hreadyout, hresp, drop;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic strobe_n, tape_feed, sample_pulse, control_register_clear;
  logic lockout_release, frame_read_ack, missing_strobe_indicator;
  logic class_b_fault, processor_halt;
  logic [6:0] hole_levels, frame_in, frame_sent;
  logic [7:0] seen;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire logic [7:0] ev = {sample_pulse, lockout_release, processor_halt,
    class_b_fault, missing_strobe_indicator, frame_read_ack,
    control_register_clear, tape_feed};
  tape_frame_capture #(.HOLDOFF_CYCLES(70), .WINDOW_CYCLES(60),
    .GRACE_CYCLES(20), .BLOCK_CYCLES(30)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .link_clk, .strobe_n,
    .hole_levels, .tape_feed, .sample_pulse, .control_register_clear,
    .lockout_release, .frame_read_ack, .missing_strobe_indicator,
    .class_b_fault, .processor_halt);
  tape_reader_model reader (.link_clk, .tape_feed, .drop, .frame_in,
    .strobe_n, .hole_levels, .frame_sent);
  // ========
  // Clocks and timeout
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    check(what, e, d & m);
  endtask : rd_chk
  task automatic wait_ev(input int b, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (ev[b] !== 1'b1 && n < lim);
    seen = ev;
    check("event", 32'h0000_0001, {31'h0, ev[b]});
    @(posedge hclk);
  endtask : wait_ev
  task automatic close_out;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // ========
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    drop = 1'b0;
    frame_in = 7'h7f;
    seed = 32'h0000_0ba2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(CTRL_OFF, '1, CTRL_RESET, "control");
    rd_chk(INPUT_OFF, '1, INPUT_RESET, "input");
    rd_chk(STATUS_OFF, '1, 32'h0000_0000, "status");
    rd_chk(8'h0c, '1, 32'h0000_0000, "unmapped");
    wr(CTRL_OFF, 32'h0000_5a5a);
    rd_chk(CTRL_OFF, '1, 32'h0000_5a5a, "control");
    wr(CTRL_OFF, 32'h0003_0000);
    repeat (3) @(posedge hclk);
    rd_chk(STATUS_OFF, 32'h0000_0014, 32'h0000_0014, "start");
    wait_ev(1, 100);
    check("first ack", 32'h0000_0001, {31'h0, seen[2]});
    check("release", 32'h0000_0001, {31'h0, seen[6]});
    check("sample", 32'h0000_0001, {31'h0, seen[7]});
    rd_chk(CTRL_OFF, '1, 32'h0000_0000, "control cleared");
    for (int i = 0; i < 8; i++) begin
      if (i > 0) wait_ev(2, 100);
      rd_chk(INPUT_OFF, '1, {25'h000_0000, frame_sent}, "frame");
      seed = lfsr(seed);
      frame_in <= (i == 0) ? 7'h00 : seed[6:0];
    end
    rd_chk(STATUS_OFF, 32'h0000_0010, 32'h0000_0000, "holdoff");
    drop <= 1'b1;
    wait_ev(3, 300);
    check("halt", 32'h0000_0003, {30'h0, seen[5:4]});
    check("feed off", 32'h0000_0000, {31'h0, seen[0]});
    rd_chk(STATUS_OFF, 32'h0000_0003, 32'h0000_0003, "fault");
    drop <= 1'b0;
    wr(STATUS_OFF, 32'h0000_0001);
    rd_chk(STATUS_OFF, 32'h0000_0003, 32'h0000_0000, "cleared");
    wait_ev(2, 100);
    wr(CTRL_OFF, 32'h0002_8000);
    wait_ev(1, 100);
    check("stop ack", 32'h0000_0000, {31'h0, seen[2]});
    check("stop release", 32'h0000_0001, {31'h0, seen[6]});
    rd_chk(STATUS_OFF, 32'h0000_002c, 32'h0000_0020, "stopped");
    wr(CTRL_OFF, 32'h0003_0000);
    rd_chk(STATUS_OFF, 32'h0000_0004, 32'h0000_0000, "blocked");
    repeat (40) @(posedge hclk);
    rd_chk(STATUS_OFF, 32'h0000_0004, 32'h0000_0004, "restart");
    wait_ev(1, 100);
    wr(CTRL_OFF, 32'h0002_8000);
    wait_ev(1, 100);
    repeat (40) @(posedge hclk);
    wr(CTRL_OFF, 32'h0003_8000);
    wait_ev(1, 100);
    check("step ack", 32'h0000_0000, {31'h0, seen[2]});
    rd_chk(INPUT_OFF, '1, {25'h000_0000, frame_sent}, "step");
    repeat (150) @(posedge hclk);
    rd_chk(STATUS_OFF, 32'h0000_0007, 32'h0000_0000, "idle");
    close_out();
  end
endmodule : tb_top
